// ===== design/alp_pkg.sv
// Shared constants for the absolute linear position output link.
// Assumes both ends run on the same 50 MHz clock rate.
package alp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned BAUD_BPS = 9600;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
    localparam int unsigned STEP_NS = 200; // Least dwell per quadrature state
    localparam int unsigned STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TMR_W = 16;

    // ------------------------------------------------------------
    // Position layout
    // ------------------------------------------------------------
    localparam int unsigned POS_W = 36;
    localparam int unsigned UPPER_W = 16;
    localparam int unsigned LOWER_W = 20;
    localparam int unsigned UPPER_LSB = 20;
    localparam int unsigned PDIV_W = 16;
    localparam logic [5:0] DIV_STEPS = 6'h24;

    // ------------------------------------------------------------
    // Serial message
    // ------------------------------------------------------------
    localparam int unsigned DATA_BITS = 7;
    localparam int unsigned FRAME_BITS = 10;
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam int unsigned DIGITS = 5;
    localparam logic [2:0] CHAR_P = 3'h0;
    localparam logic [2:0] CHAR_SIGN = 3'h1;
    localparam logic [2:0] CHAR_LAST = 3'h7;
    localparam logic [6:0] ASC_P = 7'h50;
    localparam logic [6:0] ASC_PLUS = 7'h2b;
    localparam logic [6:0] ASC_MINUS = 7'h2d;
    localparam logic [6:0] ASC_ZERO = 7'h30;
    localparam logic [6:0] ASC_CR = 7'h0d;
    localparam int unsigned DEC_WEIGHT [DIGITS] = '{10000, 1000, 100, 10, 1};
    localparam logic [16:0] DEC_TEN = 17'h0000a;

    // ------------------------------------------------------------
    // Quadrature state table: 0:(A1,B0) 1:(1,1) 2:(0,1) 3:(0,0)
    // ------------------------------------------------------------
    function automatic logic quad_a(input logic [1:0] s);
        return ~s[1];
    endfunction

    function automatic logic quad_b(input logic [1:0] s);
        return s[1] ^ s[0];
    endfunction

    function automatic logic [1:0] quad_index(input logic a, input logic b);
        return {~a, b ^ ~a};
    endfunction

endpackage

// ===== design/alp_link_if.sv
// Divided pulse output link between drive and host controller.
// Assumes one common clock; all three wires are driven one way only.
`timescale 1ns/1ps
interface alp_link_if;
    logic divided_phase_a_out;
    logic divided_phase_b_out;
    logic divided_origin_out;

    // Drive end sources all three lines
    modport dev (
        output divided_phase_a_out,
        output divided_phase_b_out,
        output divided_origin_out
    );

    // Host end only listens
    modport host (
        input divided_phase_a_out,
        input divided_phase_b_out,
        input divided_origin_out
    );
endinterface

// ===== design/alp_drive_end.sv
// Drive end: sends absolute linear position on the divided pulse outputs.
// Assumes position, divider and settings come from logic on i_mclk.
//
// What this block does
// - Position is signed 36 bits, split 16/20
// - Position counts pulses from encoder origin
// - Capture stop position at sequence start
// - Upper part sent on phase A only
// - Lower part sent as quadrature pulse train
// - Then track motion as incremental quadrature
// - Frames: 9600 bps, start, 7 data, even, stop
// - Message sent once after power-up only
// - Eight chars: P, sign, five digits, CR
// - Digits give magnitude, sign char separate
// - Both parts taken after divider setting
// - Host has UART on phase A
// - Host rebuilds upper times 1048576 plus lower
// - Host subtracts stored origin for machine position
// - Same construction under reverse direction
// - Absolute mode only if usage selects, after restart
`timescale 1ns/1ps
module alp_drive_end
    import alp_pkg::*;
#(
    parameter int unsigned P_BIT_CYCLES = BIT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    alp_link_if.dev link,
    input wire logic [POS_W-1:0] i_position,
    input wire logic i_origin_pulse,
    input wire logic [PDIV_W-1:0] i_output_pulse_divider,
    input wire logic i_direction_select,
    input wire logic i_encoder_usage_select,
    output logic o_sequence_done
);

    typedef enum logic [2:0] {
        ST_CFG,
        ST_CAPTURE,
        ST_SERIAL,
        ST_TRAIN,
        ST_INCR
    } alp_state_e;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    alp_state_e st_r, st_nxt;
    logic abs_r, abs_nxt, dir_r, dir_nxt;
    logic [POS_W-1:0] q_r, q_nxt, out_pos_r, out_pos_nxt;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [2:0] chr_r, chr_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic pa_r, pa_nxt, pb_r, pb_nxt, org_r, done_r;
    logic [5:0] dcnt_r, dcnt_nxt;
    logic run_r, run_nxt, neg_r, neg_nxt, fresh_r, fresh_nxt;
    logic [PDIV_W-1:0] dvs_r, dvs_nxt, rem_r, rem_nxt;
    logic [POS_W-1:0] quo_r, quo_nxt, res_r, res_nxt, sample, target_w;
    logic [PDIV_W:0] trial;
    logic [UPPER_W-1:0] upper_w, mag_w;
    logic [3:0] digit_w [DIGITS];

    // ------------------------------------------------------------
    // Upper part as sign and decimal digits
    // ------------------------------------------------------------
    assign upper_w = q_r[POS_W-1:UPPER_LSB];
    assign mag_w = upper_w[UPPER_W-1] ? UPPER_W'(-upper_w) : upper_w;

    // One decimal digit per weight
    for (genvar g = 0; g < DIGITS; g++) begin : g_digit
        assign digit_w[g] = 4'((32'(mag_w) / DEC_WEIGHT[g]) % 10);
    end

    // Character for a message slot
    function automatic logic [6:0] char_at(input logic [2:0] idx);
        logic [6:0] c;
        c = ASC_CR;
        if (idx == CHAR_P) begin
            c = ASC_P;
        end else if (idx == CHAR_SIGN) begin
            c = upper_w[UPPER_W-1] ? ASC_MINUS : ASC_PLUS;
        end else if (idx != CHAR_LAST) begin
            c = ASC_ZERO + {3'h0, digit_w[3'(idx - 3'h2)]};
        end
        return c;
    endfunction

    // Start bit low, LSB first, even parity, stop bit high
    function automatic logic [FRAME_BITS-1:0] frame_of(input logic [6:0] c);
        return {1'b1, ^c, c, 1'b0};
    endfunction

    // ------------------------------------------------------------
    // Free-running divider of the current position
    // ------------------------------------------------------------
    assign trial = {rem_r, quo_r[POS_W-1]};
    assign sample = dir_r ? POS_W'(-i_position) : i_position;

    // Restoring divide, one quotient bit per clock
    always_comb begin
        dcnt_nxt = dcnt_r;
        run_nxt = run_r;
        neg_nxt = neg_r;
        dvs_nxt = dvs_r;
        rem_nxt = rem_r;
        quo_nxt = quo_r;
        res_nxt = res_r;
        fresh_nxt = 1'b0;
        if (dcnt_r != 6'h00) begin
            dcnt_nxt = dcnt_r - 6'h01;
            if (trial >= {1'b0, dvs_r}) begin
                rem_nxt = PDIV_W'(trial - {1'b0, dvs_r});
                quo_nxt = {quo_r[POS_W-2:0], 1'b1};
            end else begin
                rem_nxt = trial[PDIV_W-1:0];
                quo_nxt = {quo_r[POS_W-2:0], 1'b0};
            end
        end else begin
            if (run_r) begin
                res_nxt = neg_r ? POS_W'(-quo_r) : quo_r;
                fresh_nxt = 1'b1;
            end
            run_nxt = 1'b0;
            if (st_r != ST_CFG) begin
                neg_nxt = sample[POS_W-1];
                quo_nxt = sample[POS_W-1] ? POS_W'(-sample) : sample;
                dvs_nxt = (i_output_pulse_divider == '0) ? PDIV_W'(1) : i_output_pulse_divider;
                rem_nxt = '0;
                dcnt_nxt = DIV_STEPS;
                run_nxt = 1'b1;
            end
        end
    end

    // Divider registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            dcnt_r <= '0;
            run_r <= 1'b0;
            neg_r <= 1'b0;
            dvs_r <= '0;
            rem_r <= '0;
            quo_r <= '0;
            res_r <= '0;
            fresh_r <= 1'b0;
        end else begin
            dcnt_r <= dcnt_nxt;
            run_r <= run_nxt;
            neg_r <= neg_nxt;
            dvs_r <= dvs_nxt;
            rem_r <= rem_nxt;
            quo_r <= quo_nxt;
            res_r <= res_nxt;
            fresh_r <= fresh_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output sequencer
    // ------------------------------------------------------------
    assign target_w = (st_r == ST_TRAIN) ? {{UPPER_W{1'b0}}, q_r[LOWER_W-1:0]} : res_r;

    // Message, pulse train, then incremental tracking
    always_comb begin
        st_nxt = st_r;
        abs_nxt = abs_r;
        dir_nxt = dir_r;
        q_nxt = q_r;
        shift_nxt = shift_r;
        bit_nxt = bit_r;
        chr_nxt = chr_r;
        tmr_nxt = tmr_r + TMR_W'(1);
        out_pos_nxt = out_pos_r;
        unique case (st_r)
            ST_CFG: begin
                abs_nxt = i_encoder_usage_select;
                dir_nxt = i_direction_select;
                st_nxt = ST_CAPTURE;
            end
            ST_CAPTURE: begin
                if (fresh_r) begin
                    q_nxt = res_r;
                    tmr_nxt = '0;
                    if (abs_r) begin
                        st_nxt = ST_SERIAL;
                        chr_nxt = CHAR_P;
                        bit_nxt = '0;
                        shift_nxt = frame_of(ASC_P);
                    end else begin
                        out_pos_nxt = res_r;
                        st_nxt = ST_INCR;
                    end
                end
            end
            ST_SERIAL: begin
                if (tmr_r == TMR_W'(P_BIT_CYCLES - 1)) begin
                    tmr_nxt = '0;
                    shift_nxt = {1'b1, shift_r[FRAME_BITS-1:1]};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == LAST_BIT) begin
                        bit_nxt = '0;
                        chr_nxt = chr_r + 3'h1;
                        shift_nxt = frame_of(char_at(chr_r + 3'h1));
                        if (chr_r == CHAR_LAST) begin
                            st_nxt = ST_TRAIN;
                            out_pos_nxt = '0;
                        end
                    end
                end
            end
            ST_TRAIN, ST_INCR: begin
                if (tmr_r == TMR_W'(STEP_CYCLES - 1)) begin
                    tmr_nxt = '0;
                    if ($signed(target_w) > $signed(out_pos_r)) begin
                        out_pos_nxt = out_pos_r + POS_W'(1);
                    end else if ($signed(target_w) < $signed(out_pos_r)) begin
                        out_pos_nxt = out_pos_r - POS_W'(1);
                    end else if (st_r == ST_TRAIN) begin
                        st_nxt = ST_INCR;
                        out_pos_nxt = q_r;
                    end
                end
            end
        endcase
        // Serial bits on phase A; B keeps its idle state meanwhile
        pa_nxt = (st_nxt == ST_SERIAL) ? shift_nxt[0] : quad_a(out_pos_nxt[1:0]);
        pb_nxt = quad_b(out_pos_nxt[1:0]);
    end

    // Sequencer registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= ST_CFG;
            abs_r <= 1'b0;
            dir_r <= 1'b0;
            q_r <= '0;
            shift_r <= '1;
            bit_r <= '0;
            chr_r <= '0;
            tmr_r <= '0;
            out_pos_r <= '0;
            pa_r <= 1'b1;
            pb_r <= 1'b0;
            org_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            abs_r <= abs_nxt;
            dir_r <= dir_nxt;
            q_r <= q_nxt;
            shift_r <= shift_nxt;
            bit_r <= bit_nxt;
            chr_r <= chr_nxt;
            tmr_r <= tmr_nxt;
            out_pos_r <= out_pos_nxt;
            pa_r <= pa_nxt;
            pb_r <= pb_nxt;
            org_r <= i_origin_pulse;
            done_r <= (st_nxt == ST_INCR);
        end
    end

    // Pins straight from registers
    assign link.divided_phase_a_out = pa_r;
    assign link.divided_phase_b_out = pb_r;
    assign link.divided_origin_out = org_r;
    assign o_sequence_done = done_r;

endmodule

// ===== design/alp_host_end.sv
// Host end: receives the upper part by UART and counts quadrature pulses.
// Assumes link lines are asynchronous to i_mclk and synchronises them.
`timescale 1ns/1ps
module alp_host_end
    import alp_pkg::*;
#(
    parameter int unsigned P_BIT_CYCLES = BIT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    alp_link_if.host link,
    input wire logic i_capture_origin,
    output logic o_upper_valid,
    output logic o_frame_error,
    output logic o_origin_pulse,
    output logic [POS_W-1:0] o_encoder_position,
    output logic [POS_W-1:0] o_machine_position
);

    typedef enum logic {
        RX_IDLE,
        RX_BITS
    } alp_rx_e;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] s1_r, s2_r;
    logic a_prev_r;
    alp_rx_e rx_r, rx_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [FRAME_BITS-1:0] sr_r, sr_nxt;
    logic [2:0] chr_r, chr_nxt;
    logic minus_r, minus_nxt;
    logic [16:0] mag_r, mag_nxt;
    logic [UPPER_W-1:0] upper_r, upper_nxt;
    logic done_r, done_nxt;
    logic err_r, err_nxt;
    logic [1:0] qprev_r;
    logic [POS_W-1:0] cnt_r, cnt_nxt;
    logic [POS_W-1:0] enc_r, org_r, mach_r;
    logic org_pulse_r;
    logic [1:0] qidx;
    logic [6:0] ch;

    assign qidx = quad_index(s2_r[0], s2_r[1]);
    assign ch = sr_nxt[7:1];

    // ------------------------------------------------------------
    // Receiver, message parser and pulse counter
    // ------------------------------------------------------------
    always_comb begin
        rx_nxt = rx_r;
        tmr_nxt = tmr_r + TMR_W'(1);
        bit_nxt = bit_r;
        sr_nxt = sr_r;
        chr_nxt = chr_r;
        minus_nxt = minus_r;
        mag_nxt = mag_r;
        upper_nxt = upper_r;
        done_nxt = done_r;
        err_nxt = err_r;
        cnt_nxt = cnt_r;
        unique case (rx_r)
            RX_IDLE: begin
                if (!done_r && a_prev_r && !s2_r[0]) begin
                    rx_nxt = RX_BITS;
                    tmr_nxt = TMR_W'(P_BIT_CYCLES / 2);
                    bit_nxt = '0;
                end
            end
            RX_BITS: begin
                if (tmr_r == TMR_W'(P_BIT_CYCLES - 1)) begin
                    tmr_nxt = '0;
                    sr_nxt = {s2_r[0], sr_r[FRAME_BITS-1:1]};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == 4'h0 && s2_r[0]) begin
                        rx_nxt = RX_IDLE;
                    end else if (bit_r == LAST_BIT) begin
                        rx_nxt = RX_IDLE;
                        chr_nxt = chr_r + 3'h1;
                        if ((^sr_nxt[8:1]) || !sr_nxt[9]) begin
                            err_nxt = 1'b1;
                        end
                        if (chr_r == CHAR_P) begin
                            chr_nxt = (ch == ASC_P) ? 3'h1 : 3'h0;
                            mag_nxt = '0;
                        end else if (chr_r == CHAR_SIGN) begin
                            minus_nxt = (ch == ASC_MINUS);
                        end else if (chr_r != CHAR_LAST) begin
                            mag_nxt = 17'(mag_r * DEC_TEN + {10'h000, ch - ASC_ZERO});
                        end else begin
                            upper_nxt = minus_r ? UPPER_W'(-mag_r) : UPPER_W'(mag_r);
                            done_nxt = 1'b1;
                            cnt_nxt = '0;
                        end
                    end
                end
            end
        endcase
        // Quadrature counting only once the message is in
        if (done_r) begin
            if (2'(qidx - qprev_r) == 2'h1) begin
                cnt_nxt = cnt_r + POS_W'(1);
            end else if (2'(qidx - qprev_r) == 2'h3) begin
                cnt_nxt = cnt_r - POS_W'(1);
            end
        end
    end

    // Registers, including synchronisers and position arithmetic
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 3'h1;
            s2_r <= 3'h1;
            a_prev_r <= 1'b1;
            rx_r <= RX_IDLE;
            tmr_r <= '0;
            bit_r <= '0;
            sr_r <= '0;
            chr_r <= '0;
            minus_r <= 1'b0;
            mag_r <= '0;
            upper_r <= '0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            qprev_r <= '0;
            cnt_r <= '0;
            enc_r <= '0;
            org_r <= '0;
            mach_r <= '0;
            org_pulse_r <= 1'b0;
        end else begin
            s1_r <= {link.divided_origin_out, link.divided_phase_b_out,
                     link.divided_phase_a_out};
            s2_r <= s1_r;
            a_prev_r <= s2_r[0];
            rx_r <= rx_nxt;
            tmr_r <= tmr_nxt;
            bit_r <= bit_nxt;
            sr_r <= sr_nxt;
            chr_r <= chr_nxt;
            minus_r <= minus_nxt;
            mag_r <= mag_nxt;
            upper_r <= upper_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            qprev_r <= qidx;
            cnt_r <= cnt_nxt;
            enc_r <= {upper_r, {LOWER_W{1'b0}}} + cnt_r;
            if (i_capture_origin) begin
                org_r <= enc_r;
            end
            mach_r <= enc_r - org_r;
            org_pulse_r <= s2_r[2];
        end
    end

    assign o_upper_valid = done_r;
    assign o_frame_error = err_r;
    assign o_origin_pulse = org_pulse_r;
    assign o_encoder_position = enc_r;
    assign o_machine_position = mach_r;

endmodule

// ===== verification/alp_link_chk.sv
// Checker for the divided pulse link and the drive end controls.
// Assumes one clock and the same bit time as both ends.
`timescale 1ns/1ps
module alp_link_chk
    import alp_pkg::*;
#(
    parameter int unsigned P_BIT_CYCLES = BIT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic divided_phase_a_out,
    input wire logic divided_phase_b_out,
    input wire logic divided_origin_out,
    input wire logic i_origin_pulse,
    input wire logic i_encoder_usage_select,
    input wire logic o_sequence_done
);
    localparam int BITC = int'(P_BIT_CYCLES);
    localparam int MSG_LEN = 80 * BITC;
    localparam int DWELL = int'(STEP_CYCLES) - 1;
    logic started_r;
    logic started_nxt;
    int mc_r;
    int mc_nxt;
    logic a_d_r;
    logic [1:0] ab_d_r;
    int dw_r;
    int dw_nxt;
    logic post;
    logic in_msg;

    // ----
    // Message timer from the first start bit
    // ----
    always_comb begin
        started_nxt = started_r;
        mc_nxt = mc_r;
        dw_nxt = (dw_r < 255) ? dw_r + 1 : dw_r; // Cycles since last A/B change
        if ({divided_phase_a_out, divided_phase_b_out} != ab_d_r) begin
            dw_nxt = 0;
        end
        if (started_r && mc_r < MSG_LEN) begin
            mc_nxt = mc_r + 1;
        end
        if (!started_r && i_encoder_usage_select && a_d_r && !divided_phase_a_out) begin
            started_nxt = 1'b1;
            mc_nxt = 1;
        end
    end

    // Registers only
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            started_r <= 1'b0;
            mc_r <= 0;
            a_d_r <= 1'b1;
            ab_d_r <= 2'h2;
            dw_r <= 0;
        end else begin
            started_r <= started_nxt;
            mc_r <= mc_nxt;
            a_d_r <= divided_phase_a_out;
            ab_d_r <= {divided_phase_a_out, divided_phase_b_out};
            dw_r <= dw_nxt;
        end
    end

    assign post = started_r && (mc_r == MSG_LEN);
    assign in_msg = started_r && (mc_r < MSG_LEN);

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    sequence quad_step;
        post && $changed({divided_phase_a_out, divided_phase_b_out});
    endsequence

    sequence done_rise;
        $rose(o_sequence_done) && i_encoder_usage_select;
    endsequence

    chk_reset_idle: assert property ($fell(i_rst) |-> divided_phase_a_out && // RESET
        !divided_phase_b_out && !divided_origin_out && !o_sequence_done)
        else $error("link not idle after reset");
    chk_origin_copy: assert property (!$past(i_rst) |->
        divided_origin_out == $past(i_origin_pulse)) else $error("origin not copied");
    chk_b_hold_msg: assert property (i_encoder_usage_select && !post |->
        !divided_phase_b_out) else $error("phase B moved in message");
    chk_baud_align: assert property (in_msg && $changed(divided_phase_a_out) |->
        (mc_r % BITC) == 0) else $error("serial edge off bit grid");
    chk_final_stop: assert property (started_r && mc_r == MSG_LEN - 1 |->
        divided_phase_a_out) else $error("last stop bit low");
    chk_quad_dwell: assert property (quad_step |-> dw_r >= DWELL)
        else $error("quadrature state too short");
    chk_quad_one_pin: assert property (post |->
        !($changed(divided_phase_a_out) && $changed(divided_phase_b_out)))
        else $error("both phases moved at once");
    chk_done_after_msg: assert property (done_rise |-> post)
        else $error("done before message end");
    chk_done_sticky: assert property (o_sequence_done |=> o_sequence_done)
        else $error("done dropped");
endmodule

// ===== verification/abs_linear_position_output_tb.sv
// Testbench: drive end and host end joined by the link interface.
// Assumes a shortened bit time of 16 clocks on both ends.
`timescale 1ns/1ps
module abs_linear_position_output_tb;
    import alp_pkg::*;
    localparam int unsigned BITC = 16;
    logic i_mclk;
    logic i_rst;
    logic [POS_W-1:0] pos;
    logic [PDIV_W-1:0] pdiv;
    logic dir;
    logic usage;
    logic org;
    logic cap;
    logic done;
    logic up_valid;
    logic frm_err;
    logic host_org;
    logic [POS_W-1:0] enc_pos;
    logic [POS_W-1:0] mach_pos;
    int error_cnt;
    int checks_done;

    // ----
    // Two ends, link and checker
    // ----
    alp_link_if alp_link_if_i ();
    alp_drive_end #(.P_BIT_CYCLES(BITC)) alp_drive_end_i (.i_mclk(i_mclk), .i_rst(i_rst),
        .link(alp_link_if_i.dev), .i_position(pos), .i_origin_pulse(org),
        .i_output_pulse_divider(pdiv), .i_direction_select(dir),
        .i_encoder_usage_select(usage), .o_sequence_done(done));
    alp_host_end #(.P_BIT_CYCLES(BITC)) alp_host_end_i (.i_mclk(i_mclk), .i_rst(i_rst),
        .link(alp_link_if_i.host), .i_capture_origin(cap), .o_upper_valid(up_valid),
        .o_frame_error(frm_err), .o_origin_pulse(host_org), .o_encoder_position(enc_pos),
        .o_machine_position(mach_pos));
    alp_link_chk #(.P_BIT_CYCLES(BITC)) alp_link_chk_i (.i_mclk(i_mclk), .i_rst(i_rst),
        .divided_phase_a_out(alp_link_if_i.divided_phase_a_out),
        .divided_phase_b_out(alp_link_if_i.divided_phase_b_out),
        .divided_origin_out(alp_link_if_i.divided_origin_out), .i_origin_pulse(org),
        .i_encoder_usage_select(usage), .o_sequence_done(done));

    // 50 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    task automatic cmp(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Power-up with settings applied under reset
    task automatic power_up(input logic u, input logic d, input logic [POS_W-1:0] p,
                            input logic [PDIV_W-1:0] v);
        @(negedge i_mclk);
        i_rst = 1'b1;
        usage = u;
        dir = d;
        pos = p;
        pdiv = v;
        repeat (6) @(negedge i_mclk);
        i_rst = 1'b0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge i_mclk);
            n++;
        end
        if (done !== 1'b1) begin
            cmp({35'h0, done}, 36'h1);
            summarize();
        end
        repeat (20) @(negedge i_mclk);
    endtask

    task automatic expect_abs(input logic [POS_W-1:0] exp);
        cmp(enc_pos, exp);
        cmp({35'h0, up_valid}, 36'h1);
        cmp({35'h0, frm_err}, 36'h0);
    endtask

    // One origin pulse, seen at the host within 8 clocks
    task automatic pulse_origin();
        int n;
        logic seen;
        seen = 1'b0;
        org = 1'b1;
        @(negedge i_mclk);
        org = 1'b0;
        for (n = 0; n < 8; n++) begin
            seen = seen | host_org;
            @(negedge i_mclk);
        end
        cmp({35'h0, seen}, 36'h1);
    endtask

    task automatic sc_plain();
        power_up(1'b1, 1'b0, 36'h0_0030_0007, 16'h0001);
        wait_done();
        expect_abs(36'h0_0030_0007);
    endtask

    task automatic sc_neg_max();
        power_up(1'b1, 1'b0, 36'h8_0000_0004, 16'h0001);
        wait_done();
        expect_abs(36'h8_0000_0004);
    endtask

    task automatic sc_divider();
        power_up(1'b1, 1'b0, 36'h0_0060_0011, 16'h0003);
        wait_done();
        expect_abs(36'h0_0020_0005);
    endtask

    task automatic sc_reverse();
        power_up(1'b1, 1'b1, 36'hf_ffaf_fffd, 16'h0001);
        wait_done();
        expect_abs(36'h0_0050_0003);
    endtask

    // Origin capture, tracking, then a quiet line
    task automatic sc_track();
        int n;
        logic [1:0] last;
        power_up(1'b1, 1'b0, 36'h0_0010_0002, 16'h0001);
        wait_done();
        cap = 1'b1;
        @(negedge i_mclk);
        cap = 1'b0;
        repeat (5) @(negedge i_mclk);
        pos = 36'h0_0010_0008;
        repeat (200) @(negedge i_mclk);
        cmp(mach_pos, 36'h6);
        cmp(enc_pos, 36'h0_0010_0008);
        n = 0;
        last = {alp_link_if_i.divided_phase_a_out, alp_link_if_i.divided_phase_b_out};
        repeat (2000) begin
            @(negedge i_mclk);
            if ({alp_link_if_i.divided_phase_a_out, alp_link_if_i.divided_phase_b_out} !== last)
            begin
                n++;
            end
        end
        cmp(36'(n), 36'h0);
    endtask

    task automatic sc_origin();
        power_up(1'b1, 1'b0, 36'h0_0010_0001, 16'h0001);
        repeat (300) @(negedge i_mclk);
        pulse_origin();
        wait_done();
        pulse_origin();
    endtask

    task automatic sc_incremental();
        power_up(1'b0, 1'b0, 36'h0_0030_0007, 16'h0001);
        repeat (3000) @(negedge i_mclk);
        cmp({35'h0, up_valid}, 36'h0);
        cmp({35'h0, done}, 36'h1);
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        checks_done = 0;
        i_rst = 1'b1;
        pos = '0;
        pdiv = 16'h0001;
        dir = 1'b0;
        usage = 1'b1;
        org = 1'b0;
        cap = 1'b0;
        sc_plain();
        sc_neg_max();
        sc_divider();
        sc_reverse();
        sc_track();
        sc_origin();
        sc_incremental();
        summarize();
    end
endmodule
